/* isr_pkg.sv */
package isr_pkg;

    // ----------------------------------------------------------------
    // sizes and source / destination indices
    // ----------------------------------------------------------------
    localparam int NSRC = 26;
    localparam int NDST = 4;
    localparam int NPIN = 2;
    localparam int NCPU = 2;
    localparam int SRC_AGG = 0;
    localparam int SRC_PIN0 = 1;
    localparam int SRC_CORE_LO = 3;
    localparam int NCORE = NSRC - SRC_CORE_LO;
    localparam int DST_PROCESSOR_DESTINATION_0 = 0;
    localparam int DST_PIN0 = 2;
    localparam int MODE_HI_W = 2 * NSRC - 32;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] A_LEVEL = 8'h00;
    localparam logic [7:0] A_BYPASS = 8'h04;
    localparam logic [7:0] A_MODE_LO = 8'h08;
    localparam logic [7:0] A_MODE_HI = 8'h0C;
    localparam logic [7:0] A_FORCE = 8'h10;
    localparam logic [7:0] A_LOG = 8'h14;
    localparam logic [7:0] A_ENA = 8'h18;
    localparam logic [7:0] A_ENA_CLR = 8'h1C;
    localparam logic [7:0] A_ENA_SET = 8'h20;
    localparam logic [7:0] A_ACTIVE = 8'h24;
    localparam logic [7:0] A_ROUTE0 = 8'h40;
    localparam logic [7:0] A_DVIEW0 = 8'h50;
    localparam logic [7:0] A_M_POL = 8'h60;
    localparam logic [7:0] A_M_LEVEL = 8'h64;
    localparam logic [7:0] A_M_BYPASS = 8'h68;
    localparam logic [7:0] A_M_MODE = 8'h6C;
    localparam logic [7:0] A_M_LOG = 8'h70;
    localparam logic [7:0] A_M_ENA = 8'h74;
    localparam logic [7:0] A_M_ACTIVE = 8'h78;
    localparam logic [7:0] A_PIN_IN_POL = 8'h80;
    localparam logic [7:0] A_PIN_OUT_POL = 8'h84;
    localparam logic [7:0] A_PIN_DRV = 8'h88;
    localparam logic [7:0] A_ROUTE_MASK = 8'hF0;

    // ----------------------------------------------------------------
    // reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // detection modes, two bits per source
    typedef enum logic [1:0] {
        ISR_LEVEL = 2'b00,
        ISR_ANY = 2'b01,
        ISR_FALL = 2'b10,
        ISR_RISE = 2'b11
    } isr_mode_t;

    // event for one source from its mode, present and previous level
    function automatic logic isr_event(input logic [1:0] mode, input logic lvl,
                                       input logic prev);
        case (isr_mode_t'(mode))
            ISR_LEVEL: isr_event = lvl;
            ISR_ANY: isr_event = lvl ^ prev;
            ISR_FALL: isr_event = ~lvl & prev;
            ISR_RISE: isr_event = lvl & ~prev;
            default: isr_event = 1'b0;
        endcase
    endfunction : isr_event

endpackage : isr_pkg

/* isr_det_if.sv */
interface isr_det_if #(parameter int N = 26);
    logic [N-1:0] lvl;
    logic [2*N-1:0] mode;
    logic [N-1:0] bypass;
    logic [N-1:0] force_ev;
    logic [N-1:0] clr;
    logic [N-1:0] ena;
    logic [N-1:0] log_v;
    logic [N-1:0] act;

    modport ctrl (output lvl, output mode, output bypass, output force_ev, output clr,
                  output ena, input log_v, input act);
    modport det (input lvl, input mode, input bypass, input force_ev, input clr,
                 input ena, output log_v, output act);
endinterface : isr_det_if

/* isr_detect.sv */
module isr_detect
    import isr_pkg::*;
#(
    parameter int N = 26
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control and results
    isr_det_if.det d
);

    logic [N-1:0] prev_q;
    logic [N-1:0] log_q;
    logic [N-1:0] log_d;
    logic [N-1:0] evt;

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    // one event per source from its chosen mode
    always_comb begin
        for (int i = 0; i < N; i++) begin
            evt[i] = isr_event(d.mode[2*i +: 2], d.lvl[i], prev_q[i]);
        end
    end

    // previous level for change detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= d.lvl;
        end
    end

    // ----------------------------------------------------------------
    // sticky log
    // ----------------------------------------------------------------
    // set and force beat a same-cycle clear, so no event is lost
    assign log_d = (log_q & ~d.clr) | evt | d.force_ev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            log_q <= '0;
        end else begin
            log_q <= log_d;
        end
    end

    // bypass takes the raw level and ignores log and mode
    assign d.act = (d.bypass & d.lvl | ~d.bypass & log_q) & d.ena;
    assign d.log_v = log_q;

endmodule : isr_detect

/* isr_top.sv */
// Notes on behaviour
// - raw source levels readable
// - bypass uses raw level instead
// - per source level or change detection
// - force write logs an event
// - sticky log holds after source drops
// - clear register drops chosen enable bits
// - set register raises chosen enable bits
// - active view is logged and enabled
// - route mask per destination
// - destination view is active and route
// - module inputs pass polarity first
// - module active view per module
// - pin inputs pass polarity first
// - pin outputs polarity and drive mode
// - exactly four destination outputs
// - two to processor, two to pins
// - destination indices zero to three
// - everything inside is active high
// - polarity outside the controller core
// - bit zero aggregate, bits one two pins
// - bits three to ten peripherals
// - bits eleven to twentyfive in order
// - mode zero level, others change kinds
// - write one clears, live source in level mode resets
// - routed active source reaches output
module isr_top
    import isr_pkg::*;
#(
    parameter int NMOD = 10,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // interrupt sources
    input wire logic [NCORE-1:0] CORE_SRC,
    input wire logic [NMOD-1:0] MODULE_IRQ,
    input wire logic [NPIN-1:0] PIN_IRQ_IN,
    // interrupt destinations
    output logic [NCPU-1:0] CPU_IRQ,
    output logic [NPIN-1:0] PIN_IRQ_OUT,
    output logic [NPIN-1:0] PIN_IRQ_OE,
    // axi4-lite write
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // axi4-lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) old[8*b +: 8] = nw[8*b +: 8];
        end
        merge = old;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            A_LEVEL, A_BYPASS, A_MODE_LO, A_MODE_HI, A_FORCE, A_LOG, A_ENA, A_ENA_CLR,
            A_ENA_SET, A_ACTIVE, A_M_POL, A_M_LEVEL, A_M_BYPASS, A_M_MODE, A_M_LOG,
            A_M_ENA, A_M_ACTIVE, A_PIN_IN_POL, A_PIN_OUT_POL, A_PIN_DRV: mapped = 1'b1;
            default: mapped = ((a & A_ROUTE_MASK) == A_ROUTE0) ||
                              ((a & A_ROUTE_MASK) == A_DVIEW0);
        endcase
    endfunction : mapped

    isr_det_if #(.N(NSRC)) src_if ();
    isr_det_if #(.N(NMOD)) mod_if ();

    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] rd_d;

    logic [NSRC-1:0] bypass_q;
    logic [31:0] mode_lo_q;
    logic [MODE_HI_W-1:0] mode_hi_q;
    logic [NSRC-1:0] ena_q;
    logic [NSRC-1:0] route_q [NDST];
    logic [NSRC-1:0] dview [NDST];
    logic [NMOD-1:0] m_pol_q;
    logic [NMOD-1:0] m_bypass_q;
    logic [2*NMOD-1:0] m_mode_q;
    logic [NMOD-1:0] m_ena_q;
    logic [NPIN-1:0] pin_in_pol_q;
    logic [NPIN-1:0] pin_out_pol_q;
    logic [NPIN-1:0] pin_drv_q;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;
    logic [NDST-1:0] dst_q;
    logic [NPIN-1:0] pin_out_q;
    logic [NPIN-1:0] pin_oe_q;
    logic [NSRC-1:0] src_lvl;
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_act;

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    // address and data are taken in either order, then written together
    assign AWREADY = ~aw_hold_q & ~bvalid_q;
    assign WREADY = ~w_hold_q & ~bvalid_q;
    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    assign wd = merge(RST_WORD, w_data_q, w_strb_q);
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = ~rvalid_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;

    // write channel capture and response
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= RST_WORD;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= {AWADDR[7:2], 2'b00};
            end
            if (WVALID && WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel, data latched on the address handshake
    assign ra = {ARADDR[7:2], 2'b00};

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q <= RST_WORD;
            rresp_q <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_d;
            rresp_q <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
        end else if (RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // read multiplexer, narrow fields zero extended
    always_comb begin
        rd_d = RST_WORD;
        case (ra)
            A_LEVEL: rd_d = 32'(src_lvl);
            A_BYPASS: rd_d = 32'(bypass_q);
            A_MODE_LO: rd_d = mode_lo_q;
            A_MODE_HI: rd_d = 32'(mode_hi_q);
            A_LOG: rd_d = 32'(src_if.log_v);
            A_ENA: rd_d = 32'(ena_q);
            A_ACTIVE: rd_d = 32'(src_if.act);
            A_M_POL: rd_d = 32'(m_pol_q);
            A_M_LEVEL: rd_d = 32'(mod_if.lvl);
            A_M_BYPASS: rd_d = 32'(m_bypass_q);
            A_M_MODE: rd_d = 32'(m_mode_q);
            A_M_LOG: rd_d = 32'(mod_if.log_v);
            A_M_ENA: rd_d = 32'(m_ena_q);
            A_M_ACTIVE: rd_d = 32'(mod_if.act);
            A_PIN_IN_POL: rd_d = 32'(pin_in_pol_q);
            A_PIN_OUT_POL: rd_d = 32'(pin_out_pol_q);
            A_PIN_DRV: rd_d = 32'(pin_drv_q);
            default: begin
                if ((ra & A_ROUTE_MASK) == A_ROUTE0) begin
                    rd_d = 32'(route_q[ra[3:2]]);
                end else if ((ra & A_ROUTE_MASK) == A_DVIEW0) begin
                    rd_d = 32'(dview[ra[3:2]]);
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // plain read-write settings
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            bypass_q <= '0;
            mode_lo_q <= RST_WORD;
            mode_hi_q <= '0;
            m_pol_q <= '0;
            m_bypass_q <= '0;
            m_mode_q <= '0;
            pin_in_pol_q <= '0;
            pin_out_pol_q <= '0;
            pin_drv_q <= '0;
        end else if (wr_fire) begin
            case (aw_addr_q)
                A_BYPASS: bypass_q <= NSRC'(merge(32'(bypass_q), w_data_q, w_strb_q));
                A_MODE_LO: mode_lo_q <= merge(mode_lo_q, w_data_q, w_strb_q);
                A_MODE_HI: mode_hi_q <= MODE_HI_W'(merge(32'(mode_hi_q), w_data_q, w_strb_q));
                A_M_POL: m_pol_q <= NMOD'(merge(32'(m_pol_q), w_data_q, w_strb_q));
                A_M_BYPASS: m_bypass_q <= NMOD'(merge(32'(m_bypass_q), w_data_q, w_strb_q));
                A_M_MODE: m_mode_q <= (2*NMOD)'(merge(32'(m_mode_q), w_data_q, w_strb_q));
                A_PIN_IN_POL: pin_in_pol_q <= NPIN'(merge(32'(pin_in_pol_q), w_data_q, w_strb_q));
                A_PIN_OUT_POL: pin_out_pol_q <= NPIN'(merge(32'(pin_out_pol_q),
                    w_data_q, w_strb_q));
                A_PIN_DRV: pin_drv_q <= NPIN'(merge(32'(pin_drv_q), w_data_q, w_strb_q));
                default: ;
            endcase
        end
    end

    // set and clear touch only chosen bits, so handlers need no read-modify-write
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ena_q <= '0;
        end else if (wr_fire && aw_addr_q == A_ENA) begin
            ena_q <= NSRC'(merge(32'(ena_q), w_data_q, w_strb_q));
        end else if (wr_fire && aw_addr_q == A_ENA_CLR) begin
            ena_q <= ena_q & ~NSRC'(wd);
        end else if (wr_fire && aw_addr_q == A_ENA_SET) begin
            ena_q <= ena_q | NSRC'(wd);
        end
    end

    // module enable
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            m_ena_q <= '0;
        end else if (wr_fire && aw_addr_q == A_M_ENA) begin
            m_ena_q <= NMOD'(merge(32'(m_ena_q), w_data_q, w_strb_q));
        end
    end

    // route masks, indexed by destination
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            route_q <= '{default: '0};
        end else if (wr_fire && (aw_addr_q & A_ROUTE_MASK) == A_ROUTE0) begin
            route_q[aw_addr_q[3:2]] <= NSRC'(merge(32'(route_q[aw_addr_q[3:2]]),
                                                   w_data_q, w_strb_q));
        end
    end

    // ----------------------------------------------------------------
    // source assembly
    // ----------------------------------------------------------------
    // pins are asynchronous; only the second stage is read
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= PIN_IRQ_IN;
            pin_s2_q <= pin_s1_q;
        end
    end

    // polarity is corrected before anything reaches detection
    assign pin_lvl = pin_s2_q ^ pin_in_pol_q;
    assign src_lvl = {CORE_SRC, pin_lvl, mod_if.act[NMOD-1:0] != '0};

    // module hierarchy feeds the aggregate source
    assign mod_if.lvl = MODULE_IRQ ^ m_pol_q;
    assign mod_if.mode = m_mode_q;
    assign mod_if.bypass = m_bypass_q;
    assign mod_if.force_ev = '0;
    assign mod_if.clr = (wr_fire && aw_addr_q == A_M_LOG) ? NMOD'(wd) : '0;
    assign mod_if.ena = m_ena_q;

    assign src_if.lvl = src_lvl;
    assign src_if.mode = {mode_hi_q, mode_lo_q};
    assign src_if.bypass = bypass_q;
    assign src_if.force_ev = (wr_fire && aw_addr_q == A_FORCE) ? NSRC'(wd) : '0;
    assign src_if.clr = (wr_fire && aw_addr_q == A_LOG) ? NSRC'(wd) : '0;
    assign src_if.ena = ena_q;

    isr_detect #(.N(NMOD)) u_mod_det (
        .clk(CORE_CLK),
        .rst(RST),
        .d(mod_if)
    );

    isr_detect #(.N(NSRC)) u_src_det (
        .clk(CORE_CLK),
        .rst(RST),
        .d(src_if)
    );

    // ----------------------------------------------------------------
    // destinations
    // ----------------------------------------------------------------
    // each destination sees the active sources it routes
    always_comb begin
        for (int k = 0; k < NDST; k++) begin
            dview[k] = src_if.act & route_q[k];
        end
    end

    // registered outputs; index 0,1 processor and 2,3 pins
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dst_q <= '0;
        end else begin
            for (int k = 0; k < NDST; k++) begin
                dst_q[k] <= dview[k] != '0;
            end
        end
    end

    assign CPU_IRQ = dst_q[DST_PROCESSOR_DESTINATION_0 +: NCPU];

    // polarity, then push-pull or open-collector; undriven in reset for shared wires
    assign pin_act = dst_q[DST_PIN0 +: NPIN] ^ pin_out_pol_q;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            pin_out_q <= ~pin_drv_q & pin_act;
            pin_oe_q <= ~pin_drv_q | pin_act;
        end
    end

    assign PIN_IRQ_OUT = pin_out_q;
    assign PIN_IRQ_OE = pin_oe_q;

endmodule : isr_top

/* isr_monitor.sv */
module isr_monitor
    import isr_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // destinations
    input wire logic [NCPU-1:0] CPU_IRQ,
    input wire logic [NPIN-1:0] PIN_IRQ_OUT,
    input wire logic [NPIN-1:0] PIN_IRQ_OE,
    // bus handshakes
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP
);
    // ----------------------------------------------------------------
    // protocol and reset checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // address and data both taken at one edge
    sequence s_wr_taken;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence s_rd_taken;
        ARVALID && ARREADY;
    endsequence

    a_write_answer: assert property (s_wr_taken |-> ##[1:3] BVALID)
        else $error("write response missing");
    a_read_answer: assert property (s_rd_taken |=> RVALID)
        else $error("read data late");
    a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    a_read_busy: assert property (RVALID |-> !ARREADY)
        else $error("read accepted while busy");
    a_write_busy: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted while busy");
    a_slverr_zero: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == '0)
        else $error("refused read returns data");
    a_reset_quiet: assert property ($fell(RST) |-> CPU_IRQ == '0 && !BVALID && !RVALID)
        else $error("outputs active after reset");
    a_pin_idle: assert property ($fell(RST) |=> PIN_IRQ_OE == '1 && PIN_IRQ_OUT == '0)
        else $error("pin outputs not idle low");
endmodule : isr_monitor

bind isr_top isr_monitor u_mon (.CORE_CLK(CORE_CLK), .RST(RST), .CPU_IRQ(CPU_IRQ),
    .PIN_IRQ_OUT(PIN_IRQ_OUT), .PIN_IRQ_OE(PIN_IRQ_OE), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP));

/* isr_src_model.sv */
module isr_src_model
    import isr_pkg::*;
#(
    parameter int NMOD = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels requested by the test sequence
    input wire logic [NCORE-1:0] core_req,
    input wire logic [NMOD-1:0] mod_req,
    input wire logic [NPIN-1:0] pin_req,
    // levels seen by the controller
    output logic [NCORE-1:0] core_src,
    output logic [NMOD-1:0] module_irq,
    output logic [NPIN-1:0] pin_irq
);
    // ----------------------------------------------------------------
    // source behaviour
    // ----------------------------------------------------------------
    // on-chip sources change on the core edge like real peripherals
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_src <= '0;
            module_irq <= '0;
        end else begin
            core_src <= core_req;
            module_irq <= mod_req;
        end
    end

    // board pins are unrelated to the core clock, so move them mid-cycle
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            pin_irq <= '0;
        end else begin
            pin_irq <= pin_req;
        end
    end
endmodule : isr_src_model

/* tb_interrupt_source_router.sv */
module tb_interrupt_source_router
    import isr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, cpu_irq, pin_out, pin_oe, pin_req, pin_in;
    logic [NCORE-1:0] core_src, core_req;
    logic [9:0] mod_irq, mod_req;
    int error_cnt, tests_run;

    isr_top dut (.CORE_CLK(clk), .RST(rst), .CORE_SRC(core_src), .MODULE_IRQ(mod_irq),
        .PIN_IRQ_IN(pin_in), .CPU_IRQ(cpu_irq), .PIN_IRQ_OUT(pin_out), .PIN_IRQ_OE(pin_oe),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
        .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
        .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp));
    isr_src_model u_src (.clk(clk), .rst(rst), .core_req(core_req), .mod_req(mod_req),
        .pin_req(pin_req), .core_src(core_src), .module_irq(mod_irq), .pin_irq(pin_in));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // each channel released only at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        rready <= 1'b0;
    endtask : rd

    // sources pass the model, synchroniser and log first
    task automatic drive(input logic [22:0] c, input logic [9:0] m, input logic [1:0] p);
        core_req <= c;
        mod_req <= m;
        pin_req <= p;
        repeat (8) @(posedge clk);
    endtask : drive

    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // clock, watchdog and sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // a few hundred cycles needed; wide margin
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
        {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
        {core_req, mod_req, pin_req} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(A_ENA, 0, RESP_OKAY);
        rd(A_LOG, 0, RESP_OKAY);
        rd(8'hC0, 0, RESP_SLVERR);
        wr(8'hC0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(A_ENA_SET, 32'h0000_0A0F, RESP_OKAY);
        wr(A_ENA_SET, 32'h0000_0030, RESP_OKAY);
        rd(A_ENA, 32'h0000_0A3F, RESP_OKAY);
        wr(A_ENA_CLR, 32'h0000_0203, RESP_OKAY);
        rd(A_ENA, 32'h0000_083C, RESP_OKAY);
        wr(A_ENA, 32'h0000_0008, RESP_OKAY);
        // timer 0 level routed to processor 0 and pin 0
        drive(23'h1, 0, 0);
        rd(A_LEVEL, 32'h0000_0008, RESP_OKAY);
        wr(A_LOG, 32'h0000_0008, RESP_OKAY);
        rd(A_LOG, 32'h0000_0008, RESP_OKAY);
        wr(A_ROUTE0, 32'h0000_0008, RESP_OKAY);
        wr(A_ROUTE0 + 8'h08, 32'h0000_0008, RESP_OKAY);
        rd(A_ACTIVE, 32'h0000_0008, RESP_OKAY);
        rd(A_DVIEW0, 32'h0000_0008, RESP_OKAY);
        rd(A_DVIEW0 + 8'h04, 0, RESP_OKAY);
        chk("cpu_irq", 32'h1, 32'(cpu_irq));
        chk("pin_out", 32'hD, {28'h0, pin_oe, pin_out});
        wr(A_PIN_OUT_POL, 32'h0000_0002, RESP_OKAY);
        wr(A_PIN_DRV, 32'h0000_0001, RESP_OKAY);
        drive(0, 0, 0);
        chk("pin_low", 32'hE, {28'h0, pin_oe, pin_out});
        rd(A_LOG, 32'h0000_0008, RESP_OKAY);
        wr(A_LOG, 32'h0000_0008, RESP_OKAY);
        drive(0, 0, 0);
        chk("pin_free", 32'hA, {28'h0, pin_oe, pin_out});
        chk("cpu_off", 32'h0, 32'(cpu_irq));
        wr(A_FORCE, 32'h0000_0800, RESP_OKAY);
        rd(A_LOG, 32'h0000_0800, RESP_OKAY);
        rd(A_FORCE, 0, RESP_OKAY);
        wr(A_LOG, 32'h0000_0800, RESP_OKAY);
        // every detection code on timer 1
        for (int m = 0; m < 4; m++) begin
            wr(A_MODE_LO, 32'(m) << 8, RESP_OKAY);
            drive(23'h2, 0, 0);
            rd(A_LOG, {27'h0, m != 2, 4'h0}, RESP_OKAY);
            wr(A_LOG, 32'h0000_0010, RESP_OKAY);
            rd(A_LOG, {27'h0, m == 0, 4'h0}, RESP_OKAY);
            drive(0, 0, 0);
            rd(A_LOG, {27'h0, m != 3, 4'h0}, RESP_OKAY);
            wr(A_LOG, 32'h0000_0010, RESP_OKAY);
        end
        wr(A_BYPASS, 32'h0000_0020, RESP_OKAY);
        wr(A_ENA_SET, 32'h0000_0020, RESP_OKAY);
        drive(23'h4, 0, 0);
        rd(A_ACTIVE, 32'h0000_0020, RESP_OKAY);
        drive(0, 0, 0);
        rd(A_ACTIVE, 0, RESP_OKAY);
        // port modules: module 0 inverted, module 9 straight
        wr(A_M_POL, 32'h0000_0001, RESP_OKAY);
        wr(A_M_ENA, 32'h0000_0001, RESP_OKAY);
        drive(0, 10'h200, 0);
        rd(A_M_LEVEL, 32'h0000_0201, RESP_OKAY);
        rd(A_M_LOG, 32'h0000_0201, RESP_OKAY);
        rd(A_M_ACTIVE, 32'h0000_0001, RESP_OKAY);
        rd(A_LEVEL, 32'h0000_0001, RESP_OKAY);
        wr(A_M_ENA, 0, RESP_OKAY);
        wr(A_PIN_IN_POL, 32'h0000_0002, RESP_OKAY);
        drive(23'h7F_FFFF, 0, 2'b01);
        rd(A_LEVEL, 32'h03FF_FFFE, RESP_OKAY);
        complete_run();
    end
endmodule : tb_interrupt_source_router
